// >>> verilog/prs_params.svh
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// register port geometry
`define PRS_ADDR_W 10
`define PRS_DATA_W 8

// status readback register
`define PRS_ADDR_STATUS 10'h01f
`define PRS_STATUS_RST 8'h00
`define PRS_RDATA_RST 8'h00

// status bit positions
`define PRS_BIT_LOCK 0
`define PRS_BIT_PRI 1
`define PRS_BIT_SEC 2
`define PRS_BIT_OSC 3
`define PRS_BIT_SEL 4
`define PRS_BIT_HOLD 5
`define PRS_BIT_CAL 6
`define PRS_BIT_RSVD 7

// assertion helper: edges needed to refill the sync pipe after reset
`define PRS_FILL_W 2
`define PRS_FILL_RST 2'h0
`define PRS_FILL_STEP 2'h1
`define PRS_FILL_FULL 2'h3

`endif

// >>> verilog/prs_pkg.sv
`include "prs_params.svh"

package prs_pkg;

   // raw conditions from the pll monitoring logic
   typedef struct packed {
      logic cal_done;
      logic holdover_active;
      logic secondary_ref_in_use;
      logic oscillator_above_limit;
      logic secondary_ref_above_sel1;
      logic secondary_ref_above_sel0;
      logic primary_ref_above_sel1;
      logic primary_ref_above_sel0;
      logic lock_detect;
   } prs_mon_s;

   // one register access from the serial control port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`PRS_ADDR_W-1:0] addr;
      logic [`PRS_DATA_W-1:0] wdata;
   } prs_req_s;

endpackage : prs_pkg

// >>> verilog/prs_sync.sv
`timescale 1ns/100ps

module prs_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge i_core_clk or posedge i_rst) begin
         if (i_rst) begin
            meta[b] <= 1'b0;
            o_q[b] <= 1'b0;
         end else begin
            meta[b] <= i_d[b];
            o_q[b] <= meta[b];
         end
      end
   end

endmodule : prs_sync

// >>> verilog/prs_status.sv
`timescale 1ns/100ps
`include "prs_params.svh"

module prs_status (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // monitoring logic, asynchronous to the core clock
   input wire prs_pkg::prs_mon_s i_mon,
   // threshold select configuration bit, core clock domain
   input wire logic i_thresh_sel,
   // register access from the serial control port
   input wire prs_pkg::prs_req_s i_req,
   output logic [`PRS_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid
);
   import prs_pkg::*;

   prs_mon_s mon_s;
   logic [`PRS_DATA_W-1:0] status;
   logic [`PRS_DATA_W-1:0] next_status;
   logic [`PRS_DATA_W-1:0] next_rdata;
   logic next_rvalid;
   logic rd_hit;
   logic wr_hit;
   logic [`PRS_FILL_W-1:0] fill;
   logic [`PRS_FILL_W-1:0] next_fill;

   // monitor levels come from analog detectors, so resynchronise them
   prs_sync #(
      .W($bits(prs_mon_s))
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_d(i_mon),
      .o_q(mon_s)
   );

   // assertion helper: edges since reset, saturating; the sync pipe only
   // mirrors the pins once refilled, so earlier edges are not judged
   always_comb begin
      next_fill = fill;
      if (fill != `PRS_FILL_FULL) begin
         next_fill = fill + `PRS_FILL_STEP;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         fill <= `PRS_FILL_RST;
      end else begin
         fill <= next_fill;
      end
   end

   sync_path_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      fill == `PRS_FILL_FULL |-> mon_s == $past(i_mon, 2))
      else $error("monitor level not two edges behind its pin");

   // live status word, rebuilt every cycle
   always_comb begin
      next_status = `PRS_STATUS_RST;
      next_status[`PRS_BIT_HOLD] = mon_s.holdover_active;
      next_status[`PRS_BIT_SEL] = mon_s.secondary_ref_in_use;
      next_status[`PRS_BIT_OSC] = mon_s.oscillator_above_limit;
      // select is a plain config level, no resync needed
      next_status[`PRS_BIT_SEC] = i_thresh_sel ? mon_s.secondary_ref_above_sel1
                                               : mon_s.secondary_ref_above_sel0;
      next_status[`PRS_BIT_PRI] = i_thresh_sel ? mon_s.primary_ref_above_sel1
                                               : mon_s.primary_ref_above_sel0;
      next_status[`PRS_BIT_LOCK] = mon_s.lock_detect;
      next_status[`PRS_BIT_CAL] = mon_s.cal_done;
      next_status[`PRS_BIT_RSVD] = 1'b0;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         status <= `PRS_STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // status word is one edge behind the synchronised levels
   status_hold_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_HOLD] == $past(mon_s.holdover_active))
      else $error("status holdover bit lost");

   status_select_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_SEL] == $past(mon_s.secondary_ref_in_use))
      else $error("status reference select bit lost");

   status_osc_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_OSC] == $past(mon_s.oscillator_above_limit))
      else $error("status oscillator limit bit lost");

   status_sec_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_SEC] ==
         ($past(i_thresh_sel) ? $past(mon_s.secondary_ref_above_sel1)
                              : $past(mon_s.secondary_ref_above_sel0)))
      else $error("status secondary threshold bit lost");

   status_pri_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_PRI] ==
         ($past(i_thresh_sel) ? $past(mon_s.primary_ref_above_sel1)
                              : $past(mon_s.primary_ref_above_sel0)))
      else $error("status primary threshold bit lost");

   status_lock_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_LOCK] == $past(mon_s.lock_detect))
      else $error("status lock bit lost");

   status_cal_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      status[`PRS_BIT_CAL] == $past(mon_s.cal_done))
      else $error("status calibration bit lost");

   // register port decode
   assign rd_hit = i_req.rd && (i_req.addr == `PRS_ADDR_STATUS);
   assign wr_hit = i_req.wr && (i_req.addr == `PRS_ADDR_STATUS);

   // read answer: one cycle after the request, data held until next read
   // writes have no path into status at all
   always_comb begin
      next_rdata = o_reg_rdata;
      next_rvalid = 1'b0;
      if (rd_hit) begin
         next_rdata = status;
         next_rvalid = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= `PRS_RDATA_RST;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rdata <= next_rdata;
         o_reg_rvalid <= next_rvalid;
      end
   end

   // a read at cycle t returns conditions synchronised at t-1
   hold_bit_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_HOLD] == $past(mon_s.holdover_active, 2))
      else $error("holdover bit does not follow holdover state");

   ref_select_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_SEL] == $past(mon_s.secondary_ref_in_use, 2))
      else $error("reference select bit wrong");

   osc_limit_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_OSC] == $past(mon_s.oscillator_above_limit, 2))
      else $error("oscillator limit bit wrong");

   sec_thresh_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_SEC] ==
         ($past(i_thresh_sel, 2) ? $past(mon_s.secondary_ref_above_sel1, 2)
                                 : $past(mon_s.secondary_ref_above_sel0, 2)))
      else $error("secondary threshold bit wrong");

   pri_thresh_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_PRI] ==
         ($past(i_thresh_sel, 2) ? $past(mon_s.primary_ref_above_sel1, 2)
                                 : $past(mon_s.primary_ref_above_sel0, 2)))
      else $error("primary threshold bit wrong");

   lock_detect_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rdata[`PRS_BIT_LOCK] == $past(mon_s.lock_detect, 2))
      else $error("lock bit does not follow lock detector");

   cal_pending_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit && !$past(mon_s.cal_done) |=> !o_reg_rdata[`PRS_BIT_CAL])
      else $error("calibration bit set before calibration done");

   write_ignored_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      wr_hit && !rd_hit |=> !o_reg_rvalid && $stable(o_reg_rdata))
      else $error("write to status register had an effect");

   read_answer_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      !rd_hit |=> !o_reg_rvalid)
      else $error("answer without a read of the status register");

   read_served_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit |=> o_reg_rvalid)
      else $error("status read got no answer");

   rdata_hold_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      !rd_hit |=> $stable(o_reg_rdata))
      else $error("read data moved without a status read");

   cal_done_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_hit && $past(mon_s.cal_done) |=> o_reg_rdata[`PRS_BIT_CAL])
      else $error("calibration bit clear after calibration done");

   rsvd_zero_a:
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_reg_rvalid |-> !o_reg_rdata[`PRS_BIT_RSVD])
      else $error("reserved bit read as one");

endmodule : prs_status

// >>> verification/test_prs_status.sv
`timescale 1ns/100ps
`include "prs_params.svh"

module test_prs_status;
   import prs_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   prs_mon_s i_mon = '0;
   logic i_thresh_sel = 1'b0;
   prs_req_s i_req = '0;
   logic [`PRS_DATA_W-1:0] o_reg_rdata;
   logic o_reg_rvalid;
   logic [`PRS_DATA_W-1:0] exp_q[$];
   logic [15:0] lfsr = 16'h004b;
   logic [9:0] other;
   int fail_count = 0;
   int total_checks = 0;

   prs_status dut (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_mon(i_mon),
      .i_thresh_sel(i_thresh_sel),
      .i_req(i_req),
      .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid)
   );

   initial begin
      forever #25 i_core_clk = ~i_core_clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // expected word; the select picks which monitor comparison is shown
   function automatic logic [7:0] status_of(input prs_mon_s m, input logic sel);
      return {1'b0, m.cal_done, m.holdover_active, m.secondary_ref_in_use,
              m.oscillator_above_limit,
              sel ? m.secondary_ref_above_sel1 : m.secondary_ref_above_sel0,
              sel ? m.primary_ref_above_sel1 : m.primary_ref_above_sel0, m.lock_detect};
   endfunction : status_of

   task check(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check

   task conclude;
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task access(input logic rd, input logic wr, input logic [9:0] addr);
      lfsr = lfsr_next(lfsr);
      @(posedge i_core_clk);
      i_req <= '{rd: rd, wr: wr, addr: addr, wdata: lfsr[7:0]};
      if (rd && addr == `PRS_ADDR_STATUS) exp_q.push_back(status_of(i_mon, i_thresh_sel));
   endtask : access

   task idle(input int n);
      repeat (n) @(posedge i_core_clk) i_req <= '0;
   endtask : idle

   // any answer with no pending read means a write or unmapped access was served
   always @(posedge i_core_clk) begin
      if (i_rst === 1'b0 && o_reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) check(8'h01, 8'h00);
         else check(o_reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 60; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge i_core_clk);
         i_mon <= lfsr[8:0];
         i_thresh_sel <= lfsr[9];
         other = (lfsr[15:6] == `PRS_ADDR_STATUS) ? 10'h020 : lfsr[15:6];
         idle(4);
         // back to back: read, ignored write, read with write, stray access, read
         access(1'b1, 1'b0, `PRS_ADDR_STATUS);
         access(1'b0, 1'b1, `PRS_ADDR_STATUS);
         access(1'b1, 1'b1, `PRS_ADDR_STATUS);
         access(1'b1, lfsr[3], other);
         access(1'b1, 1'b0, `PRS_ADDR_STATUS);
         idle(3);
      end
      for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge i_core_clk);
      if (exp_q.size() != 0) fail_count++;
      conclude();
   end
endmodule : test_prs_status
